// ===== logic/slpmc_pkg.sv
package slpmc_pkg;
  // sleep mode selector codes
  localparam logic [3:0] SLPMC_MODE_PIN = 4'h1;
  localparam logic [3:0] SLPMC_MODE_CYCLIC = 4'h4;
  localparam logic [3:0] SLPMC_MODE_CYCPIN = 4'h5;
  localparam logic [3:0] SLPMC_MODE_SUPPORT = 4'h7;
  localparam logic [3:0] SLPMC_MODE_SYNC = 4'h8;
  // sleep option bit forcing full wake time
  localparam int SLPMC_OPT_FULLWAKE = 8;
  // routing roles and transmit option
  localparam logic [2:0] SLPMC_ROLE_COORD = 3'h1;
  localparam logic [2:0] SLPMC_ROLE_END = 3'h4;
  localparam logic [7:0] SLPMC_TXOPT_QUEUE = 8'h40;
  // pin configuration codes
  localparam logic [1:0] SLPMC_CFG_ON = 2'h1;
  localparam logic [1:0] SLPMC_CFG_SSEL = 2'h0;
  // time unit: one tick is 1 us at 50 MHz
  localparam int SLPMC_CLK_MHZ = 50;
  localparam int SLPMC_TICK_US = 1;
  localparam int SLPMC_TICK_CYCLES = SLPMC_TICK_US * SLPMC_CLK_MHZ;
  localparam logic [15:0] SLPMC_TIMER_RESET = 16'h0000;
  localparam int SLPMC_PERIOD_W = 16;
  // link message codes
  typedef enum logic [1:0] {SLPMC_MSG_NONE, SLPMC_MSG_POLL, SLPMC_MSG_SYNC, SLPMC_MSG_DATA} slpmc_msg_type;
endpackage

// ===== logic/slpmc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
// radio link between the sleeping device and the coordinating node
interface slpmc_link_if;
  import slpmc_pkg::*;
  slpmc_msg_type devMsg;
  logic devMsgValid;
  slpmc_msg_type netMsg;
  logic netMsgValid;
  logic [15:0] netSleepPeriod;
  logic [15:0] netWakeTime;
  logic [15:0] devSleepPeriod;
  logic [15:0] devWakeTime;
  logic devParamsNew;
  modport device (output devMsg, output devMsgValid, input netMsg, input netMsgValid,
    input netSleepPeriod, input netWakeTime, output devSleepPeriod, output devWakeTime, output devParamsNew);
  modport coord (input devMsg, input devMsgValid, output netMsg, output netMsgValid,
    output netSleepPeriod, output netWakeTime, input devSleepPeriod, input devWakeTime, input devParamsNew);
endinterface
`default_nettype wire

// ===== logic/slpmc_device.sv
// Functional notes
// (R1) mode 4: cyclic wake, poll coordinator each period
// (R2) coordinator sends queued data on poll
// (R3) no data: sleep again; data: stay awake
// (R4) option bit 8 forces full wake time
// (R5) coordinator role 1, sleeper role 4
// (R6) senders use option 0x40 to queue
// (R7) flow control low on each cyclic wake
// (R8) awake indicator after sleep_period_count periods
// (R9) mode 5: low pin wakes, holds awake
// (R10) short low pulse gives full wake time
// (R11) activity restarts wake timer
// (R12) pin mode: high sleeps, low wakes
// (R13) SPI select replaces pin when config 0
// (R14) mode 7: synced, never sleeps, sync anytime
// (R15) mode 8: timed sleep, deaf while asleep
// (R16) own timing only until synchronized
// (R17) mode 8 indicator follows awake state
// (R18) flow config 1: high asleep, low awake
// (R19) unsynced: poll for sync, then sleep
// (R20) one sync per wake, routers rebroadcast
// (R21) local timing change adopted network-wide
`timescale 1ns/1ps
`default_nettype none
module slpmc_device
  import slpmc_pkg::*;
#(
  parameter int PERIOD_W = SLPMC_PERIOD_W,
  parameter int TICK_CYCLES = SLPMC_TICK_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // configuration
  input wire logic [3:0] sleepModeSelect,
  input wire logic [PERIOD_W-1:0] cycleSleepPeriod,
  input wire logic [PERIOD_W-1:0] wakeTime,
  input wire logic [7:0] sleepPeriodCount,
  input wire logic [15:0] sleepOptions,
  input wire logic [1:0] flowSignalConfig,
  input wire logic [1:0] sleepInputConfig,
  input wire logic [1:0] sleepIndicatorConfig,
  input wire logic [2:0] routingRole,
  input wire logic timingUpdate,
  // host pins
  input wire logic sleepRequestPin,
  input wire logic spiSelectPin,
  input wire logic serialActivity,
  output logic ctsN,
  output logic awakeIndicator,
  output logic serialEnable,
  // status
  output logic synced,
  // link
  slpmc_link_if.device link
);
  import slpmc_pkg::*;

  initial begin
    if (PERIOD_W < 2 || PERIOD_W > 16 || TICK_CYCLES < 1) $error("slpmc_device: bad parameters");
  end

  typedef enum {SLPMC_SLEEP, SLPMC_AWAKE} slpmc_state_type;
  slpmc_state_type state_q, state_d;

  logic [1:0] pinSync1_q, pinSync2_q;
  logic pinPrev_q;
  logic [15:0] tick_q;
  logic [PERIOD_W-1:0] timer_q, timer_d;
  logic [7:0] periods_q;
  logic synced_q;
  logic [PERIOD_W-1:0] sleepPer_q, wakePer_q;
  logic msgValid_q, paramsNew_q, polled_q;
  slpmc_msg_type msg_q;

  // pin select and mode decode
  // each sleep pin is synchronised on its own before the choice, so neither raw sleep pin feeds logic
  wire pinSel = (sleepInputConfig == SLPMC_CFG_SSEL) ? pinSync2_q[1] : pinSync2_q[0]; // R13
  wire modePin = (sleepModeSelect == SLPMC_MODE_PIN);
  wire modeCyc = (sleepModeSelect == SLPMC_MODE_CYCLIC);
  wire modeCycPin = (sleepModeSelect == SLPMC_MODE_CYCPIN);
  wire modeSupport = (sleepModeSelect == SLPMC_MODE_SUPPORT);
  wire modeSync = (sleepModeSelect == SLPMC_MODE_SYNC);
  wire asyncCyclic = modeCyc | modeCycPin;
  wire tickNow = (tick_q == 16'(TICK_CYCLES - 1));
  wire timerDone = (timer_q == '0);
  wire pinFall = pinPrev_q & ~pinSel;
  wire pinLow = ~pinSel;
  wire netActive = state_q == SLPMC_AWAKE;
  // radio reception is ignored while asleep, except in support mode
  wire rxValid = link.netMsgValid & (netActive | modeSupport); // R15
  wire rxData = rxValid & (link.netMsg == SLPMC_MSG_DATA);
  wire rxSync = rxValid & (link.netMsg == SLPMC_MSG_SYNC);
  wire activity = rxData | (serialActivity & netActive);
  wire fullWake = sleepOptions[SLPMC_OPT_FULLWAKE]; // R4
  // own timing until synchronized, then network timing
  wire [PERIOD_W-1:0] usePeriod = synced_q ? sleepPer_q : cycleSleepPeriod; // R16
  wire [PERIOD_W-1:0] useWake = synced_q ? wakePer_q : wakeTime; // R16
  // awake window for async cycle without data is a single poll slot
  wire [PERIOD_W-1:0] pollSlot = PERIOD_W'(1);

  // state and timer next values
  always_comb begin
    state_d = state_q;
    timer_d = tickNow && !timerDone ? timer_q - PERIOD_W'(1) : timer_q;
    unique case (state_q)
      SLPMC_SLEEP: begin
        if (modePin && pinLow) begin
          state_d = SLPMC_AWAKE; // R12
        end else if (modeCycPin && pinFall) begin
          state_d = SLPMC_AWAKE; // R9
          timer_d = useWake; // R10
        end else if (modeSupport) begin
          state_d = SLPMC_AWAKE; // R14
        end else if ((asyncCyclic || modeSync) && timerDone) begin
          state_d = SLPMC_AWAKE; // R1
          timer_d = (asyncCyclic && !fullWake) ? pollSlot : useWake; // R4
        end
      end
      SLPMC_AWAKE: begin
        if (modePin) begin
          if (!pinLow) state_d = SLPMC_SLEEP; // R12
        end else if (modeSupport) begin
          state_d = SLPMC_AWAKE; // R14
        end else if (activity && asyncCyclic) begin
          timer_d = useWake; // R11 R3
        end else if (modeCycPin && pinLow) begin
          timer_d = timer_q; // R9
        end else if (timerDone) begin
          state_d = SLPMC_SLEEP; // R3
          timer_d = usePeriod; // R19
        end
        if (rxSync && modeSync) begin
          timer_d = link.netWakeTime[PERIOD_W-1:0]; // R19
        end
      end
      default: state_d = SLPMC_SLEEP;
    endcase
  end

  // pin synchroniser and tick prescaler
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pinSync1_q <= 2'h3;
      pinSync2_q <= 2'h3;
      pinPrev_q <= 1'b1;
      tick_q <= SLPMC_TIMER_RESET;
    end else begin
      pinSync1_q <= {spiSelectPin, sleepRequestPin};
      pinSync2_q <= pinSync1_q;
      pinPrev_q <= pinSel;
      tick_q <= tickNow ? SLPMC_TIMER_RESET : tick_q + 16'h0001;
    end
  end

  // main state and timer
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_q <= SLPMC_SLEEP;
      timer_q <= '0;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
    end
  end

  // sleep period counter for the awake indicator
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      periods_q <= 8'h00;
    end else if (activity) begin
      periods_q <= 8'h00;
    end else if (state_q == SLPMC_AWAKE && state_d == SLPMC_SLEEP && periods_q != sleepPeriodCount) begin
      periods_q <= periods_q + 8'h01; // R8
    end
  end

  // synchronisation and network timing
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      synced_q <= 1'b0;
      sleepPer_q <= '0;
      wakePer_q <= '0;
    end else if (timingUpdate && (modeSync || modeSupport)) begin
      synced_q <= 1'b1; // R21
      sleepPer_q <= cycleSleepPeriod;
      wakePer_q <= wakeTime;
    end else if (rxSync && (modeSync || modeSupport)) begin
      synced_q <= 1'b1; // R19
      sleepPer_q <= link.netSleepPeriod[PERIOD_W-1:0]; // R16
      wakePer_q <= link.netWakeTime[PERIOD_W-1:0];
    end
  end

  // outgoing messages: poll on async wake, sync request when unsynced, sync relay
  wire wakeEdge = state_q == SLPMC_SLEEP && state_d == SLPMC_AWAKE;
  wire relaySync = rxSync && (routingRole != SLPMC_ROLE_END) && !modeSupport; // R20
  wire answerJoin = modeSupport && synced_q && link.netMsgValid && link.netMsg == SLPMC_MSG_POLL; // R14
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      msgValid_q <= 1'b0;
      msg_q <= SLPMC_MSG_NONE;
      paramsNew_q <= 1'b0;
      polled_q <= 1'b0;
    end else begin
      msgValid_q <= 1'b0;
      msg_q <= SLPMC_MSG_NONE;
      paramsNew_q <= timingUpdate; // R21
      polled_q <= wakeEdge;
      if (wakeEdge && (asyncCyclic || (modeSync && !synced_q))) begin
        msgValid_q <= 1'b1; // R1 R19
        msg_q <= SLPMC_MSG_POLL;
      end else if (relaySync || answerJoin) begin
        msgValid_q <= 1'b1; // R20 R14
        msg_q <= SLPMC_MSG_SYNC;
      end
    end
  end

  // host pins
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ctsN <= 1'b1;
      awakeIndicator <= 1'b0;
      serialEnable <= 1'b0;
    end else begin
      ctsN <= (flowSignalConfig == SLPMC_CFG_ON) ? !netActive : 1'b1; // R7 R18
      if (sleepIndicatorConfig != SLPMC_CFG_ON) begin
        awakeIndicator <= 1'b0;
      end else if (asyncCyclic) begin
        awakeIndicator <= netActive && (periods_q == sleepPeriodCount); // R8
      end else begin
        awakeIndicator <= netActive; // R17
      end
      serialEnable <= netActive; // R15
    end
  end

  assign synced = synced_q;
  assign link.devMsg = msg_q;
  assign link.devMsgValid = msgValid_q;
  assign link.devSleepPeriod = 16'(cycleSleepPeriod);
  assign link.devWakeTime = 16'(wakeTime);
  assign link.devParamsNew = paramsNew_q;
endmodule
`default_nettype wire

// ===== logic/slpmc_coord.sv
`timescale 1ns/1ps
`default_nettype none
module slpmc_coord
  import slpmc_pkg::*;
#(
  parameter int PERIOD_W = SLPMC_PERIOD_W,
  parameter int TICK_CYCLES = SLPMC_TICK_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // user side
  input wire logic [2:0] routingRole,
  input wire logic [7:0] transmitOptions,
  input wire logic queueData,
  input wire logic syncMaster,
  input wire logic [PERIOD_W-1:0] cycleSleepPeriod,
  input wire logic [PERIOD_W-1:0] wakeTime,
  output logic pending,
  output logic [PERIOD_W-1:0] netSleepOut,
  output logic [PERIOD_W-1:0] netWakeOut,
  // link
  slpmc_link_if.coord link
);
  import slpmc_pkg::*;

  initial begin
    if (PERIOD_W < 2 || PERIOD_W > 16 || TICK_CYCLES < 1) $error("slpmc_coord: bad parameters");
  end

  logic pending_q, valid_q;
  slpmc_msg_type msg_q;
  logic [15:0] tick_q;
  logic [PERIOD_W-1:0] cnt_q, sleep_q, wake_q;
  logic awakePhase_q;

  wire tickNow = tick_q == 16'(TICK_CYCLES - 1);
  wire isCoord = routingRole == SLPMC_ROLE_COORD; // R5
  // only queued-option traffic is held for the sleeper
  wire enqueue = queueData && transmitOptions == SLPMC_TXOPT_QUEUE; // R6
  wire pollIn = link.devMsgValid && link.devMsg == SLPMC_MSG_POLL;
  wire sendData = isCoord && pollIn && pending_q; // R2
  wire cycleEnd = tickNow && cnt_q == '0;
  wire sendSync = syncMaster && cycleEnd && !awakePhase_q; // R20

  // queue flag, set wins over clear
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pending_q <= 1'b0;
    end else begin
      pending_q <= enqueue | (pending_q & ~sendData); // R2
    end
  end

  // network timing, adopting newest local change
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sleep_q <= '0;
      wake_q <= '0;
    end else if (link.devParamsNew) begin
      sleep_q <= link.devSleepPeriod[PERIOD_W-1:0];
      wake_q <= link.devWakeTime[PERIOD_W-1:0];
    end else if (sleep_q == '0) begin
      sleep_q <= cycleSleepPeriod;
      wake_q <= wakeTime;
    end
  end

  // wake/sleep cycle for sync broadcast
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      tick_q <= SLPMC_TIMER_RESET;
      cnt_q <= '0;
      awakePhase_q <= 1'b0;
    end else begin
      tick_q <= tickNow ? SLPMC_TIMER_RESET : tick_q + 16'h0001;
      if (tickNow) begin
        if (cnt_q == '0) begin
          awakePhase_q <= !awakePhase_q;
          cnt_q <= awakePhase_q ? sleep_q : wake_q;
        end else begin
          cnt_q <= cnt_q - PERIOD_W'(1);
        end
      end
    end
  end

  // outgoing messages
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      valid_q <= 1'b0;
      msg_q <= SLPMC_MSG_NONE;
    end else begin
      valid_q <= sendData | sendSync;
      msg_q <= sendSync ? SLPMC_MSG_SYNC : (sendData ? SLPMC_MSG_DATA : SLPMC_MSG_NONE);
    end
  end

  assign pending = pending_q;
  assign netSleepOut = sleep_q;
  assign netWakeOut = wake_q;
  assign link.netMsg = msg_q;
  assign link.netMsgValid = valid_q;
  assign link.netSleepPeriod = 16'(sleep_q);
  assign link.netWakeTime = 16'(wake_q);
endmodule
`default_nettype wire

// ===== bench/slpmc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module slpmc_checker (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // link signals
  input wire slpmc_pkg::slpmc_msg_type devMsg,
  input wire logic devMsgValid,
  input wire slpmc_pkg::slpmc_msg_type netMsg,
  input wire logic netMsgValid,
  input wire logic [15:0] netSleepPeriod,
  input wire logic [15:0] netWakeTime,
  input wire logic [15:0] devSleepPeriod,
  input wire logic [15:0] devWakeTime,
  input wire logic devParamsNew
);
  import slpmc_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // message kind decodes
  wire logic devPoll;
  wire logic netData;
  wire logic netSync;
  assign devPoll = devMsgValid && devMsg == SLPMC_MSG_POLL;
  assign netData = netMsgValid && netMsg == SLPMC_MSG_DATA;
  assign netSync = netMsgValid && netMsg == SLPMC_MSG_SYNC;
  a_poll_single: assert property (devPoll |=> !devPoll)
    else $error("poll repeated on the next cycle");
  a_data_on_poll: assert property (netData |-> $past(devPoll))
    else $error("data sent without a poll one cycle before");
  a_net_kind: assert property (netMsgValid |-> netMsg != SLPMC_MSG_POLL && netMsg != SLPMC_MSG_NONE)
    else $error("coordinator sent an empty or poll message");
  a_dev_kind: assert property (devMsgValid |-> devMsg != SLPMC_MSG_NONE)
    else $error("device sent an empty message");
  a_sync_once: assert property (netSync |=> !netSync)
    else $error("two sync messages back to back");
  a_sync_times: assert property (netSync |-> netSleepPeriod != 16'h0000 && netWakeTime != 16'h0000)
    else $error("sync sent without timing");
  a_params_pulse: assert property (devParamsNew |=> !devParamsNew)
    else $error("timing change pulse longer than one cycle");
  a_params_adopt: assert property (devParamsNew |-> ##[1:1000] netSleepPeriod == devSleepPeriod)
    else $error("network did not adopt the local sleep period");
  // main scenarios
  c_poll_data: cover property (devPoll ##1 netData);
  c_sync: cover property (netSync);
  c_params: cover property (devParamsNew);
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import slpmc_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] mode = SLPMC_MODE_PIN;
  logic [15:0] devPeriod = 16'h00c8;
  logic [15:0] devWake = 16'h001e;
  logic [15:0] opts = 16'h0000;
  logic [15:0] cPeriod = 16'h0064;
  logic [15:0] cWake = 16'h0014;
  logic [15:0] seed = 16'h0006;
  logic [15:0] expPeriod;
  logic [15:0] netSleepOut, netWakeOut;
  logic [7:0] txOpt = 8'h00;
  logic [1:0] inCfg = SLPMC_CFG_SSEL;
  logic [1:0] ind = SLPMC_CFG_ON;
  logic tUpd = 1'b0, pinN = 1'b1, ssel = 1'b1, act = 1'b0, qData = 1'b0, sMaster = 1'b0;
  logic ctsN, awake, serEn, synced, pending;
  int mismatches = 0;
  int checks = 0;
  slpmc_msg_type expMsg[$];
  slpmc_link_if link();
  // both ends joined over one link, roles as a coordinator and an end node
  slpmc_device #(.TICK_CYCLES(1)) slpmc_device_inst (.clock(clock), .reset_n(reset_n),
    .sleepModeSelect(mode), .cycleSleepPeriod(devPeriod), .wakeTime(devWake), .sleepPeriodCount(8'h01),
    .sleepOptions(opts), .flowSignalConfig(ind), .sleepInputConfig(inCfg), .sleepIndicatorConfig(ind),
    .routingRole(SLPMC_ROLE_END), .timingUpdate(tUpd), .sleepRequestPin(pinN), .spiSelectPin(ssel),
    .serialActivity(act), .ctsN(ctsN), .awakeIndicator(awake), .serialEnable(serEn), .synced(synced),
    .link(link));
  slpmc_coord #(.TICK_CYCLES(1)) slpmc_coord_inst (.clock(clock), .reset_n(reset_n),
    .routingRole(SLPMC_ROLE_COORD), .transmitOptions(txOpt), .queueData(qData), .syncMaster(sMaster),
    .cycleSleepPeriod(cPeriod), .wakeTime(cWake), .pending(pending), .netSleepOut(netSleepOut),
    .netWakeOut(netWakeOut), .link(link));
  slpmc_checker chk (.clock(clock), .reset_n(reset_n), .devMsg(link.devMsg), .devMsgValid(link.devMsgValid),
    .netMsg(link.netMsg), .netMsgValid(link.netMsgValid), .netSleepPeriod(link.netSleepPeriod),
    .netWakeTime(link.netWakeTime), .devSleepPeriod(link.devSleepPeriod), .devWakeTime(link.devWakeTime),
    .devParamsNew(link.devParamsNew));
  // clock generator
  initial begin
    forever #10 clock = ~clock;
  end
  function automatic logic [15:0] nextRnd(input logic [15:0] s);
    logic [15:0] x;
    x = s ^ (s << 7);
    x = x ^ (x >> 9);
    return x ^ (x << 8);
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // wait for flow control (0) or sync status (1) to reach a level
  task automatic waitOn(input int which, input logic v);
    int n;
    n = 0;
    while ((which ? synced : ctsN) !== v && n < 3000) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // link monitor: oldest expected reply against each message from the coordinator while an expected reply is queued
  always @(negedge clock) begin
    if (reset_n && link.netMsgValid === 1'b1 && expMsg.size() > 0) begin
      check(link.netMsg, expMsg.pop_front());
    end
  end
  // watchdog
  initial begin
    #(20 * 30000);
    mismatches++;
    summarize();
  end
  initial begin
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    cyc(2);
    check(ctsN, 1'b1);
    check(awake, 1'b0);
    // select pin in place of the request pin, then the request pin itself
    @(posedge clock) ssel <= 1'b0;
    waitOn(0, 1'b0);
    check(ctsN, 1'b0);
    @(posedge clock) ssel <= 1'b1;
    waitOn(0, 1'b1);
    check(ctsN, 1'b1);
    @(posedge clock) inCfg <= SLPMC_CFG_ON;
    pinN <= 1'b0;
    waitOn(0, 1'b0);
    check(ctsN, 1'b0);
    @(posedge clock) pinN <= 1'b1;
    waitOn(0, 1'b1);
    $display("test pin sleep done");
    // queueing needs the queue option, then a cyclic poll fetches it
    @(posedge clock) qData <= 1'b1;
    @(posedge clock) qData <= 1'b0;
    cyc(3);
    check(pending, 1'b0);
    @(posedge clock) txOpt <= SLPMC_TXOPT_QUEUE;
    qData <= 1'b1;
    @(posedge clock) qData <= 1'b0;
    cyc(3);
    check(pending, 1'b1);
    expMsg.push_back(SLPMC_MSG_DATA);
    @(posedge clock) mode <= SLPMC_MODE_CYCLIC;
    waitOn(0, 1'b0);
    check(ctsN, 1'b0);
    cyc(20);
    check(16'(expMsg.size()), 16'h0000);
    check(pending, 1'b0);
    check(ctsN, 1'b0);
    check(awake, 1'b0);
    @(posedge clock) act <= 1'b1;
    cyc(40);
    check(ctsN, 1'b0);
    @(posedge clock) act <= 1'b0;
    opts <= 16'h0100;
    waitOn(0, 1'b1);
    waitOn(0, 1'b0);
    cyc(20);
    check(ctsN, 1'b0);
    check(awake, 1'b1);
    @(posedge clock) opts <= 16'h0000;
    waitOn(0, 1'b1);
    $display("test cyclic poll done");
    // pin wake in cyclic mode: short pulse, then a held level
    @(posedge clock) mode <= SLPMC_MODE_CYCPIN;
    pinN <= 1'b0;
    @(posedge clock) pinN <= 1'b1;
    cyc(20);
    check(ctsN, 1'b0);
    @(posedge clock) pinN <= 1'b0;
    cyc(80);
    check(ctsN, 1'b0);
    @(posedge clock) pinN <= 1'b1;
    waitOn(0, 1'b1);
    check(ctsN, 1'b1);
    $display("test pin wake done");
    // synchronous sleep, later a random local period spread to the network
    @(posedge clock) sMaster <= 1'b1;
    mode <= SLPMC_MODE_SYNC;
    expMsg.push_back(SLPMC_MSG_SYNC);
    waitOn(1, 1'b1);
    check(synced, 1'b1);
    for (int i = 0; i < 8; i++) begin
      seed = nextRnd(seed);
      cyc(1 + int'(seed[3:0]));
      check(awake, !ctsN);
      check(serEn, !ctsN);
    end
    seed = nextRnd(seed);
    expPeriod = 16'h0028 + {11'h000, seed[4:0]};
    @(posedge clock) devPeriod <= expPeriod;
    tUpd <= 1'b1;
    @(posedge clock) tUpd <= 1'b0;
    for (int n = 0; n < 1000 && netSleepOut !== expPeriod; n++) begin
      cyc(1);
    end
    check(netSleepOut, expPeriod);
    $display("test sync sleep done");
    // support node keeps awake across the network's sleep
    @(posedge clock) mode <= SLPMC_MODE_SUPPORT;
    cyc(20);
    for (int i = 0; i < 8; i++) begin
      cyc(25);
      check(ctsN, 1'b0);
    end
    $display("test support node done");
    summarize();
  end
endmodule
`default_nettype wire
